// ### include/pwm_art_pkg.sv
/*
  package for the 8-bit auto-reload pwm timer: register byte addresses,
  field positions, reset values and the bus response codes.
  assumes a 32-bit axi4-lite slave with one register per aligned word.
*/
package pwm_art_pkg;
  localparam int          ADDR_W          = 6;
  // register byte addresses, one aligned word each
  localparam logic [5:0]  DUTY_BASE_ADDR  = 6'h00;
  localparam logic [5:0]  WOC_ADDR        = 6'h10;
  localparam logic [5:0]  TCS_ADDR        = 6'h14;
  localparam logic [5:0]  LCW_ADDR        = 6'h18;
  localparam logic [5:0]  RELOAD_ADDR     = 6'h1C;
  localparam logic [5:0]  CCS_ADDR        = 6'h20;
  localparam logic [5:0]  CAP_BASE_ADDR   = 6'h24;
  // timer_control_status fields
  localparam int          EXT_SEL_BIT     = 7;
  localparam int          DIV_HI_BIT      = 6;
  localparam int          DIV_LO_BIT      = 4;
  localparam int          CNT_EN_BIT      = 3;
  localparam int          FORCE_BIT       = 2;
  localparam int          OVF_IE_BIT      = 1;
  localparam int          OVF_FLAG_BIT    = 0;
  // capture_control_status fields
  localparam int          EDGE_LO_BIT     = 4;
  localparam int          CIE_LO_BIT      = 2;
  localparam int          CFLAG_LO_BIT    = 0;
  // waveform_output_control fields
  localparam int          OE_LO_BIT       = 4;
  localparam int          POL_LO_BIT      = 0;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [6:0]  PRESC_RESET     = 7'h00;
  localparam logic [7:0]  COUNT_TOP       = 8'hFF;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ### logic/pwm_auto_reload_timer.sv
/*
  8-bit auto-reload timer with four pwm channels and two input captures,
  register file on axi4-lite.
  assumes ref_clk at 20 MHz; pins and the external clock are asynchronous
  and pass a two-flop synchroniser; the external clock runs well below
  ref_clk/2 so each rising edge is seen.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
// Overview of operation
// RULE1 - control bit 7 picks cpu clock or external clock for the prescaler
// RULE2 - divider field bits 6:4 divides prescaler input by two to the power
// RULE3 - count enable bit 3 low freezes counter and prescaler; high runs
// RULE4 - force reload bit 2 always reads back as zero
// RULE5 - writing force reload loads counter from reload value, clears prescaler
// RULE6 - overflow irq asserts when flag set and irq enable bit 1 is set
// RULE7 - overflow flag set on FFh wrap, cleared by reading control register
// RULE8 - live counter window reads live count, writes load the counter
// RULE9 - each overflow reloads counter from reload value register
// RULE10 - at overflow each pwm output switches level per its polarity
// RULE11 - pwm control bits 7:4 enable each channel onto its pin
// RULE12 - polarity 0 gives high at or below compare, low above; 1 inverts
// RULE13 - changing a polarity bit inverts the output immediately
// RULE14 - duty register gives second edge; reload value gives common first
// RULE15 - capture control bits 7:6 read as zero
// RULE16 - capture edge bits 5:4: 0 falling, 1 rising edge captures
// RULE17 - capture irq enable bits 3:2, one per capture channel
// RULE18 - capture flags bits 1:0 set on capture, cleared by reading capture
// RULE19 - capture register holds latched count; writes ignored
// RULE20 - every timer register resets to zero
// RULE21 - compare value copied from duty register at each overflow
// RULE22 - after capture, further captures blocked until register read
// RULE23 - counter increments once per prescaler output tick
// RULE24 - counter loads by window write or force reload clear prescaler
`timescale 1ns/1ps
module pwm_auto_reload_timer #(
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2
) (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic [pwm_art_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pwm_art_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        ext_clock_pin,
  input  wire logic [NUM_CAP-1:0]          capture_input_pin,
  output logic [NUM_PWM-1:0]               waveform_output_pin,
  output logic [NUM_PWM-1:0]               waveform_output_oe,
  output logic                             overflow_irq,
  output logic                             capture_irq
);
  import pwm_art_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0]        aw_addr;
    logic                     aw_have;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     w_have;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
    logic [1:0]               ext_sync;
    logic                     ext_prev;
    logic [NUM_CAP-1:0]       cap_s1;
    logic [NUM_CAP-1:0]       cap_s2;
    logic [NUM_CAP-1:0]       cap_prev;
    logic                     ext_sel;
    logic [2:0]               div_sel;
    logic                     cnt_en;
    logic                     ovf_ie;
    logic                     ovf_flag;
    logic [7:0]               count;
    logic [6:0]               presc;
    logic [7:0]               reload;
    logic [NUM_PWM-1:0]       out_en;
    logic [NUM_PWM-1:0]       polarity;
    logic [NUM_PWM-1:0][7:0]  duty;
    logic [NUM_PWM-1:0][7:0]  compare;
    logic [NUM_PWM-1:0]       raw_level;
    logic [NUM_CAP-1:0]       edge_sel;
    logic [NUM_CAP-1:0]       cap_ie;
    logic [NUM_CAP-1:0]       cap_flag;
    logic [NUM_CAP-1:0][7:0]  cap_data;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic       wr_go;
  logic       rd_go;
  logic       in_tick;
  logic       cnt_tick;
  logic [6:0] presc_inc;
  logic [6:0] tap_mask;
  logic [7:0] rd_val;
  logic       rd_hit;
  logic       wr_hit;
  logic [7:0] wbyte;
  logic       overflow;

  //////////////////////////////////////////////////////////////////////////
  // bus handshake: address and data taken in either order
  assign s_axi_awready = !st_ff.aw_have && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_have && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = st_ff.rdata;
  assign wr_go = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wbyte = st_ff.w_strb[0] ? st_ff.w_data[7:0] : REG_RESET;

  //////////////////////////////////////////////////////////////////////////
  // prescaler tap and overflow detection
  always_comb begin
    tap_mask  = 7'((8'h01 << st_ff.div_sel) - 8'h01);
    in_tick   = st_ff.ext_sel ? (st_ff.ext_sync[1] && !st_ff.ext_prev)
                              : 1'b1; // RULE1
    presc_inc = st_ff.presc + 7'h01;
    cnt_tick  = st_ff.cnt_en && in_tick
                && ((st_ff.presc & tap_mask) == tap_mask); // RULE2 RULE3
    overflow  = cnt_tick && (st_ff.count == COUNT_TOP);
  end

  //////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    rd_val = REG_RESET;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      TCS_ADDR: rd_val = {st_ff.ext_sel, st_ff.div_sel, st_ff.cnt_en,
                          1'b0, st_ff.ovf_ie, st_ff.ovf_flag}; // RULE4
      LCW_ADDR:    rd_val = st_ff.count; // RULE8
      RELOAD_ADDR: rd_val = st_ff.reload;
      WOC_ADDR:    rd_val = {st_ff.out_en, st_ff.polarity};
      CCS_ADDR:    rd_val = {2'b00, st_ff.edge_sel, st_ff.cap_ie,
                             st_ff.cap_flag}; // RULE15
      CAP_BASE_ADDR:         rd_val = st_ff.cap_data[0];
      CAP_BASE_ADDR + 6'h04: rd_val = st_ff.cap_data[1];
      DUTY_BASE_ADDR:        rd_val = st_ff.duty[0];
      DUTY_BASE_ADDR + 6'h04: rd_val = st_ff.duty[1];
      DUTY_BASE_ADDR + 6'h08: rd_val = st_ff.duty[2];
      DUTY_BASE_ADDR + 6'h0C: rd_val = st_ff.duty[3];
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_hit = 1'b1;
    unique case (st_ff.aw_addr)
      TCS_ADDR, LCW_ADDR, RELOAD_ADDR, WOC_ADDR, CCS_ADDR,
      CAP_BASE_ADDR, CAP_BASE_ADDR + 6'h04,
      DUTY_BASE_ADDR, DUTY_BASE_ADDR + 6'h04,
      DUTY_BASE_ADDR + 6'h08, DUTY_BASE_ADDR + 6'h0C: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    // synchronisers
    nxt_st.ext_sync = {st_ff.ext_sync[0], ext_clock_pin};
    nxt_st.ext_prev = st_ff.ext_sync[1];
    nxt_st.cap_s1   = capture_input_pin;
    nxt_st.cap_s2   = st_ff.cap_s1;
    nxt_st.cap_prev = st_ff.cap_s2;

    // bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_addr = s_axi_awaddr;
      nxt_st.aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
      nxt_st.w_have = 1'b1;
    end
    if (wr_go) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = {24'h000000, rd_val};
      nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // counter and prescaler
    if (st_ff.cnt_en && in_tick) begin
      nxt_st.presc = presc_inc; // RULE3
    end
    if (cnt_tick) begin
      nxt_st.count = overflow ? st_ff.reload
                              : st_ff.count + 8'h01; // RULE23 RULE9
    end
    for (int i = 0; i < NUM_PWM; i++) begin
      if (overflow) begin
        nxt_st.compare[i]   = st_ff.duty[i]; // RULE21
        nxt_st.raw_level[i] = 1'b1; // RULE10 RULE14
      end else if (cnt_tick && st_ff.count == st_ff.compare[i]) begin
        nxt_st.raw_level[i] = 1'b0; // RULE12 RULE14
      end
    end

    // read side effects
    if (rd_go && s_axi_araddr == TCS_ADDR) begin
      nxt_st.ovf_flag = 1'b0; // RULE7
    end
    for (int c = 0; c < NUM_CAP; c++) begin
      if (rd_go && s_axi_araddr == CAP_BASE_ADDR + 6'(4 * c)) begin
        nxt_st.cap_flag[c] = 1'b0; // RULE18 RULE22
      end
    end

    // register writes
    if (wr_go && st_ff.w_strb[0]) begin
      unique case (st_ff.aw_addr)
        TCS_ADDR: begin
          nxt_st.ext_sel = wbyte[EXT_SEL_BIT];
          nxt_st.div_sel = wbyte[DIV_HI_BIT:DIV_LO_BIT];
          nxt_st.cnt_en  = wbyte[CNT_EN_BIT];
          nxt_st.ovf_ie  = wbyte[OVF_IE_BIT];
          if (wbyte[FORCE_BIT]) begin
            nxt_st.count = st_ff.reload; // RULE5
            nxt_st.presc = PRESC_RESET; // RULE24
          end
        end
        LCW_ADDR: begin
          nxt_st.count = wbyte; // RULE8
          nxt_st.presc = PRESC_RESET; // RULE24
        end
        RELOAD_ADDR: nxt_st.reload = wbyte;
        WOC_ADDR: begin
          nxt_st.out_en   = wbyte[OE_LO_BIT +: NUM_PWM];
          nxt_st.polarity = wbyte[POL_LO_BIT +: NUM_PWM];
        end
        CCS_ADDR: begin
          nxt_st.edge_sel = wbyte[EDGE_LO_BIT +: NUM_CAP];
          nxt_st.cap_ie   = wbyte[CIE_LO_BIT +: NUM_CAP];
        end
        DUTY_BASE_ADDR:         nxt_st.duty[0] = wbyte;
        DUTY_BASE_ADDR + 6'h04: nxt_st.duty[1] = wbyte;
        DUTY_BASE_ADDR + 6'h08: nxt_st.duty[2] = wbyte;
        DUTY_BASE_ADDR + 6'h0C: nxt_st.duty[3] = wbyte;
        default: ; // capture registers are read-only: RULE19
      endcase
    end

    // overflow set wins over its read clear; a capture sets only a flag that is already clear
    if (overflow) begin
      nxt_st.ovf_flag = 1'b1; // RULE7
    end
    for (int c = 0; c < NUM_CAP; c++) begin
      if (!st_ff.cap_flag[c]
          && (st_ff.cap_s2[c] != st_ff.cap_prev[c])
          && (st_ff.cap_s2[c] == st_ff.edge_sel[c])) begin // RULE16
        nxt_st.cap_flag[c] = 1'b1; // RULE18
        nxt_st.cap_data[c] = st_ff.count; // RULE19 RULE22
      end
    end

    if (sys_rst) begin
      nxt_st = '0; // RULE20
    end
  end

  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign waveform_output_pin = (st_ff.raw_level ^ st_ff.polarity)
                               & st_ff.out_en; // RULE13 RULE12 RULE11
  assign waveform_output_oe  = st_ff.out_en; // RULE11
  assign overflow_irq = st_ff.ovf_flag && st_ff.ovf_ie; // RULE6
  assign capture_irq  = |(st_ff.cap_flag & st_ff.cap_ie); // RULE17
endmodule

// ### testbench/pwm_timer_monitor.sv
/*
  port checker for the auto-reload pwm timer, bound to its top module.
  assumes one read at a time on the register bus.
*/
`timescale 1ns/1ps
module pwm_timer_monitor
  import pwm_art_pkg::*;
#(
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2
) (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic [ADDR_W-1:0]   s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic [NUM_CAP-1:0]  capture_input_pin,
  input wire logic [NUM_PWM-1:0]  waveform_output_pin,
  input wire logic [NUM_PWM-1:0]  waveform_output_oe,
  input wire logic                overflow_irq,
  input wire logic                capture_irq
);
  logic [ADDR_W-1:0] ar_ff;
  logic              tcs_rd;
  logic              ccs_rd;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge ref_clk) begin
    if (s_axi_arvalid && s_axi_arready) ar_ff <= s_axi_araddr;
  end
  assign tcs_rd = s_axi_rvalid && (ar_ff == TCS_ADDR);
  assign ccs_rd = s_axi_rvalid && (ar_ff == CCS_ADDR);
  ////////////////////////////////////////////////////////////////////////////
  out_gate_a: assert property (
    waveform_output_oe == $past(waveform_output_oe) |->
      (waveform_output_pin & ~waveform_output_oe) == '0)
    else $error("pwm pin driven while disabled");
  rst_quiet_a: assert property (
    $fell(sys_rst) |-> !overflow_irq && !capture_irq &&
      waveform_output_oe == '0 && waveform_output_pin == '0)
    else $error("outputs not quiet after reset");
  rsvd_zero_a: assert property (
    ccs_rd |-> s_axi_rdata[31:6] == '0)
    else $error("capture control reserved bits set");
  force_zero_a: assert property (
    tcs_rd |-> !s_axi_rdata[FORCE_BIT])
    else $error("force reload bit read as one");
  ovf_irq_a: assert property (
    tcs_rd && !s_axi_rdata[OVF_IE_BIT] |-> !overflow_irq)
    else $error("overflow irq while disabled");
  ovf_seen_a: assert property (
    tcs_rd && s_axi_rdata[OVF_IE_BIT] && s_axi_rdata[OVF_FLAG_BIT] |->
      $past(overflow_irq))
    else $error("overflow flag set without irq");
  cap_edge_a: assert property (
    $rose(capture_irq) |->
      $past(capture_input_pin, 1) != $past(capture_input_pin, 6))
    else $error("capture irq without pin edge");
  cap_pend_a: assert property (
    ccs_rd && (s_axi_rdata[3:2] & s_axi_rdata[1:0]) != 2'h0 |-> capture_irq)
    else $error("capture irq missing");
  cap_width_a: assert property (
    s_axi_rvalid && ar_ff >= CAP_BASE_ADDR |-> s_axi_rdata[31:8] == '0)
    else $error("capture data wider than a byte");
endmodule
bind pwm_auto_reload_timer pwm_timer_monitor #(
  .NUM_PWM(NUM_PWM),
  .NUM_CAP(NUM_CAP)
) u_mon (.ref_clk, .sys_rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .capture_input_pin, .waveform_output_pin,
  .waveform_output_oe, .overflow_irq, .capture_irq);

// ### testbench/pwm_far_model.sv
/*
  far side model: drives the capture pins and the external clock pin.
  assumes the timer synchronises both to ref_clk.
*/
`timescale 1ns/1ps
module pwm_far_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] waveform_output_pin,
  output logic            ext_clock_pin,
  output logic [1:0]      capture_input_pin
);
  initial begin
    ext_clock_pin = 1'b0;
    capture_input_pin = 2'h2;
  end
  // external clock idles low between bursts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge ref_clk);
      ext_clock_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext_clock_pin <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic set_cap(input int ch, input logic v);
    @(posedge ref_clk);
    capture_input_pin[ch] <= v;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// ### testbench/pwm_auto_reload_timer_tb_top.sv
/*
  self-checking bench for the auto-reload pwm timer.
  assumes the far side model drives all pins the timer reads.
*/
`timescale 1ns/1ps
module pwm_auto_reload_timer_tb_top;
  import pwm_art_pkg::*;
  logic        ref_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, ext_clock_pin;
  logic        overflow_irq, capture_irq;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, waveform_output_pin, waveform_output_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, capture_input_pin, rs;
  logic [7:0]  duty [4] = '{8'hF8, 8'hF4, 8'hF2, 8'hF6};
  int          num_errors, comparisons;
  pwm_auto_reload_timer u_dut (.ref_clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_clock_pin, .capture_input_pin,
    .waveform_output_pin, .waveform_output_oe, .overflow_irq, .capture_irq);
  pwm_far_model u_far (.ref_clk, .waveform_output_pin, .ext_clock_pin,
    .capture_input_pin);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic timeout;
    num_errors++;
    $display("CHECK FAILED %0t no answer", $time);
    finish_test;
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [7:0] d,
                        input logic [1:0] er = RESP_OKAY);
    int i;
    logic [1:0] bs;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    bs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 40) timeout;
    chk(32'(bs), 32'(er));
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp,
                        input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 40) timeout;
    chk(32'(rs), 32'(er));
    if (exp !== 32'hFFFF_FFFF) chk(rd, exp);
  endtask
  // pin level from frozen count in rd and polarity p
  task automatic pins_chk(input logic [3:0] p);
    logic [3:0] e;
    for (int i = 0; i < 4; i++) e[i] = (rd[7:0] <= duty[i]) ^ p[i];
    chk({28'h0, waveform_output_pin}, {28'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a < 11; a++) rd_chk(6'(a * 4), 32'h0);
    rd_chk(6'h3C, 32'h0, RESP_SLVERR);
    axi_wr(6'h3C, 8'hFF, RESP_SLVERR);
    rd_chk(6'h3C, 32'h0, RESP_SLVERR);
    rd_chk(RELOAD_ADDR, 32'h0);
  endtask
  task automatic t_count;
    axi_wr(RELOAD_ADDR, 8'hF0);
    axi_wr(TCS_ADDR, 8'h04);
    rd_chk(LCW_ADDR, 32'hF0);
    rd_chk(TCS_ADDR, 32'h00);
    axi_wr(LCW_ADDR, 8'hFD);
    repeat (20) @(posedge ref_clk);
    rd_chk(LCW_ADDR, 32'hFD);
    axi_wr(TCS_ADDR, 8'h0A);
    for (int i = 0; i < 50 && overflow_irq !== 1'b1; i++) @(posedge ref_clk);
    chk(32'(overflow_irq), 32'h1);
    axi_wr(TCS_ADDR, 8'h02);
    rd_chk(LCW_ADDR, 32'hFFFF_FFFF);
    chk(32'(rd >= 32'hF0 && rd < 32'hF8), 32'h1);
    rd_chk(TCS_ADDR, 32'h03);
    rd_chk(TCS_ADDR, 32'h02);
    chk(32'(overflow_irq), 32'h0);
  endtask
  task automatic t_pwm;
    for (int i = 0; i < 4; i++) axi_wr(6'(i * 4), duty[i]);
    axi_wr(WOC_ADDR, 8'hF5);
    axi_wr(TCS_ADDR, 8'h08);
    repeat (60) @(posedge ref_clk);
    axi_wr(TCS_ADDR, 8'h00);
    rd_chk(LCW_ADDR, 32'hFFFF_FFFF);
    pins_chk(4'h5);
    chk({28'h0, waveform_output_oe}, 32'hF);
    axi_wr(WOC_ADDR, 8'hFA);
    pins_chk(4'hA);
    axi_wr(DUTY_BASE_ADDR, 8'h00);
    pins_chk(4'hA);
  endtask
  task automatic t_cap;
    logic [31:0] c;
    c = rd;
    axi_wr(CCS_ADDR, 8'h1C);
    u_far.set_cap(0, 1'b1);
    chk(32'(capture_irq), 32'h1);
    rd_chk(CCS_ADDR, 32'h1D);
    axi_wr(LCW_ADDR, 8'h33);
    u_far.set_cap(0, 1'b0);
    u_far.set_cap(0, 1'b1);
    rd_chk(CAP_BASE_ADDR, c);
    rd_chk(CCS_ADDR, 32'h1C);
    axi_wr(CAP_BASE_ADDR, 8'hAA);
    rd_chk(CAP_BASE_ADDR, c);
    u_far.set_cap(1, 1'b0);
    rd_chk(CAP_BASE_ADDR + 6'h4, 32'h33);
    u_far.set_cap(0, 1'b0);
    rd_chk(CCS_ADDR, 32'h1C);
  endtask
  task automatic t_ext;
    axi_wr(TCS_ADDR, 8'h88);
    axi_wr(LCW_ADDR, 8'h10);
    u_far.ext_pulses(5);
    rd_chk(LCW_ADDR, 32'h15);
    axi_wr(TCS_ADDR, 8'hB8);
    axi_wr(LCW_ADDR, 8'h40);
    u_far.ext_pulses(16);
    rd_chk(LCW_ADDR, 32'h42);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    sys_rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_count();
    t_pwm();
    t_cap();
    t_ext();
    finish_test();
  end
endmodule
